// ---- shared/spsc_pkg.sv ----
// supply control serial port: shared constants, field layout and state type
// assumes a single 100 MHz clock domain on the device side
package spsc_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ    = 100_000_000;             // ref_clk rate
  localparam int SW_HZ     = 1_500_000;               // converter switching rate
  localparam int SW_PER    = CLK_HZ / SW_HZ;          // cycles per switching period
  localparam int SW_HALF   = SW_PER / 2;              // half period, 180 degree offset
  localparam int SW_CNT_W  = 7;                       // width of period counter

  // ----------------------------------------------------------------
  // sizes and byte layout
  // ----------------------------------------------------------------
  localparam int NSUP      = 3;                       // bias, reset, offset
  localparam int LVL_W     = 4;                       // level select width
  localparam int BYTE_W    = 8;                       // serial character width
  localparam int ADDR_W    = 7;                       // command address width
  localparam int CMD_RD    = 7;                       // command bit: 1 = read
  localparam int CTL_ON    = 4;                       // on/off bit in a control byte
  localparam int ST_CL_LSB = 3;                       // current limit bits in status byte
  localparam logic [2:0] LAST_BIT = 3'h7;             // last bit index of a byte

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADR_BIAS  = 7'h00;    // bias control
  localparam logic [ADDR_W-1:0] ADR_RSTR  = 7'h01;    // reset rail control
  localparam logic [ADDR_W-1:0] ADR_OFFS  = 7'h02;    // offset control
  localparam logic [ADDR_W-1:0] ADR_LIVE  = 7'h03;    // unlatched faults, read only
  localparam logic [ADDR_W-1:0] ADR_LATCH = 7'h04;    // latched faults, write 1 clears

  localparam int SUP_BIAS = 0;                        // supply index of bias rail
  localparam int SUP_RSTR = 1;                        // supply index of reset rail
  localparam int SUP_OFFS = 2;                        // supply index of offset rail

  // ----------------------------------------------------------------
  // input synchroniser layout
  // ----------------------------------------------------------------
  localparam int NSYNC  = 9;                          // sck, sel, sdi, 3 uv, 3 cl
  localparam int SY_SCK = 0;
  localparam int SY_SEL = 1;
  localparam int SY_SDI = 2;
  localparam int SY_UV  = 3;
  localparam int SY_CL  = 6;
  localparam logic [NSYNC-1:0] SYNC_RST = 9'h002;     // select idles high

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CMD  = 2'b01,
    ST_DATA = 2'b11,
    ST_DONE = 2'b10
  } spsc_state_e;
endpackage : spsc_pkg

// ---- rtl/spsc_top.sv ----
// supply control serial port slave with switching phase generator
// assumes: a serial master clocks bits, faults arrive as async levels,
// open-drain pins are resolved outside from the output enables
// Function
// - switchers at 1.5 MHz, 180 degrees apart
// - per supply: four-bit level, on/off bit
// - live and latched undervoltage, current-limit faults
// - full-duplex byte link, one master
// - select high: idle, data output released
// - select falling starts a new access
// - select high mid-access discards partial transfer
// - input bits sampled on clock falling edge
// - output bits change on clock rising edge
// - open-drain active-low service request output
// - no minimum clock rate, static clock ok
`timescale 1ns/1ps
module spsc_top (
  input  wire logic                      ref_clk,              // 100 MHz clock
  input  wire logic                      reset,                // sync, active high
  input  wire logic                      port_serial_clock,    // serial clock from master
  input  wire logic                      port_select_n,        // access frame, low true
  input  wire logic                      port_serial_in,       // data from master
  output logic                           port_serial_out,      // open-drain data level
  output logic                           port_serial_out_oe,   // high while pulling low
  output logic                           service_req_n,        // open-drain request level
  output logic                           service_req_n_oe,     // high while pulling low
  input  wire logic [spsc_pkg::NSUP-1:0] undervoltage_flag,    // live uv, bit per supply
  input  wire logic [spsc_pkg::NSUP-1:0] current_limit_flag,   // live cl, bit per supply
  output logic [spsc_pkg::LVL_W-1:0]     bias_level,           // bias rail level select
  output logic [spsc_pkg::LVL_W-1:0]     reset_level,          // reset rail level select
  output logic [spsc_pkg::LVL_W-1:0]     offset_level,         // offset rail level select
  output logic                           bias_on,              // bias rail enable
  output logic                           reset_on,             // reset rail enable
  output logic                           offset_on,            // offset rail enable
  output logic                           bias_switch_drive,    // bias switch gate
  output logic                           reset_switch_drive    // reset switch gate
);
  import spsc_pkg::*;

  if (SW_PER < 2 || SW_PER >= (1 << SW_CNT_W)) begin : g_sw_chk
    $error("switching period does not fit its counter");
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [NSYNC-1:0] sy1, sy2, sy3, filt;
  logic [NSYNC-1:0] next_filt;
  logic [NSYNC-1:0] raw_in;

  assign raw_in = {current_limit_flag, undervoltage_flag,
                   port_serial_in, port_select_n, port_serial_clock};

  // a level counts only once the second and third stages agree
  always_comb begin
    next_filt = filt;
    for (int i = 0; i < NSYNC; i++) begin
      if (sy2[i] == sy3[i]) begin
        next_filt[i] = sy3[i];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sy1  <= SYNC_RST;
      sy2  <= SYNC_RST;
      sy3  <= SYNC_RST;
      filt <= SYNC_RST;
    end else begin
      sy1  <= raw_in;
      sy2  <= sy1;
      sy3  <= sy2;
      filt <= next_filt;
    end
  end

  logic sck_d;
  logic sck_rise, sck_fall, sel_f, sdi_f;
  logic [NSUP-1:0] uv_live, cl_live;

  assign sel_f    = filt[SY_SEL];
  assign sdi_f    = filt[SY_SDI];
  assign uv_live  = filt[SY_UV +: NSUP];
  assign cl_live  = filt[SY_CL +: NSUP];
  // edges found on the filtered clock; a static clock simply yields none
  // no minimum rate
  assign sck_rise = filt[SY_SCK] & ~sck_d;
  assign sck_fall = ~filt[SY_SCK] & sck_d;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sck_d <= 1'b0;
    end else begin
      sck_d <= filt[SY_SCK];
    end
  end

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  logic [LVL_W-1:0] lvl [NSUP];
  logic [NSUP-1:0]  on_bits;
  logic [NSUP-1:0]  uv_lat, cl_lat;

  function automatic logic [BYTE_W-1:0] rd_mux(input logic [ADDR_W-1:0] a);
    logic [BYTE_W-1:0] v;
    v = '0;
    case (a)
      ADR_BIAS:  v = {3'h0, on_bits[SUP_BIAS], lvl[SUP_BIAS]};
      ADR_RSTR:  v = {3'h0, on_bits[SUP_RSTR], lvl[SUP_RSTR]};
      ADR_OFFS:  v = {3'h0, on_bits[SUP_OFFS], lvl[SUP_OFFS]};
      ADR_LIVE:  v = {2'h0, cl_live, uv_live};
      ADR_LATCH: v = {2'h0, cl_lat, uv_lat};
      default:   v = '0;
    endcase
    return v;
  endfunction : rd_mux

  // ----------------------------------------------------------------
  // serial engine
  // ----------------------------------------------------------------
  spsc_state_e       state, next_state;
  logic [2:0]        bit_cnt, next_bit_cnt;
  logic [BYTE_W-1:0] shreg, next_shreg;
  logic [BYTE_W-1:0] cmd, next_cmd;
  logic [BYTE_W-1:0] tx, next_tx;
  logic              sdo_oe, next_sdo_oe;
  logic              wr_en;
  logic [BYTE_W-1:0] in_byte;

  assign in_byte = {shreg[BYTE_W-2:0], sdi_f};

  // one command byte then one data byte; extra clocks are ignored
  always_comb begin
    next_state   = state;
    next_bit_cnt = bit_cnt;
    next_shreg   = shreg;
    next_cmd     = cmd;
    next_tx      = tx;
    next_sdo_oe  = sdo_oe;
    wr_en        = 1'b0;
    if (sel_f) begin
      next_state   = ST_IDLE;
      next_bit_cnt = '0;
      next_sdo_oe  = 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          next_state   = ST_CMD;
          next_bit_cnt = '0;
        end
        ST_CMD, ST_DATA: begin
          if (sck_fall) begin
            next_shreg   = in_byte;
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == LAST_BIT) begin
              if (state == ST_CMD) begin
                next_cmd   = in_byte;
                next_tx    = rd_mux(in_byte[ADDR_W-1:0]);
                next_state = ST_DATA;
              end else begin
                wr_en      = ~cmd[CMD_RD];
                next_state = ST_DONE;
              end
            end
          end
          if (sck_rise && state == ST_DATA && cmd[CMD_RD]) begin
            next_sdo_oe = ~tx[BYTE_W-1];
            next_tx     = {tx[BYTE_W-2:0], 1'b0};
          end
        end
        ST_DONE: begin
          if (sck_rise) begin
            next_sdo_oe = 1'b0;
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state   <= ST_IDLE;
      bit_cnt <= '0;
      shreg   <= '0;
      cmd     <= '0;
      tx      <= '0;
      sdo_oe  <= 1'b0;
    end else begin
      state   <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg   <= next_shreg;
      cmd     <= next_cmd;
      tx      <= next_tx;
      sdo_oe  <= next_sdo_oe;
    end
  end

  // open drain: only ever pulls low, the master's pull-up gives ones
  assign port_serial_out    = 1'b0;
  assign port_serial_out_oe = sdo_oe;

  // ----------------------------------------------------------------
  // control and fault registers
  // ----------------------------------------------------------------
  logic [LVL_W-1:0] next_lvl [NSUP];
  logic [NSUP-1:0]  next_on, next_uv_lat, next_cl_lat;
  logic [NSUP-1:0]  clr_uv, clr_cl;
  logic             irq_oe, next_irq_oe;

  always_comb begin
    next_lvl = lvl;
    next_on  = on_bits;
    for (int s = 0; s < NSUP; s++) begin
      if (wr_en && cmd[ADDR_W-1:0] == ADDR_W'(s)) begin
        next_lvl[s] = in_byte[LVL_W-1:0];
        next_on[s]  = in_byte[CTL_ON];
      end
    end
  end

  // sticky faults; a new fault beats a clear
  always_comb begin
    clr_uv = '0;
    clr_cl = '0;
    if (wr_en && cmd[ADDR_W-1:0] == ADR_LATCH) begin
      clr_uv = in_byte[NSUP-1:0];
      clr_cl = in_byte[ST_CL_LSB +: NSUP];
    end
    next_uv_lat = (uv_lat & ~clr_uv) | uv_live;
    next_cl_lat = (cl_lat & ~clr_cl) | cl_live;
    next_irq_oe = |{next_uv_lat, next_cl_lat};
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int s = 0; s < NSUP; s++) begin
        lvl[s] <= '0;
      end
      on_bits <= '0;
      uv_lat  <= '0;
      cl_lat  <= '0;
      irq_oe  <= 1'b0;
    end else begin
      lvl     <= next_lvl;
      on_bits <= next_on;
      uv_lat  <= next_uv_lat;
      cl_lat  <= next_cl_lat;
      irq_oe  <= next_irq_oe;
    end
  end

  assign bias_level       = lvl[SUP_BIAS];
  assign reset_level      = lvl[SUP_RSTR];
  assign offset_level     = lvl[SUP_OFFS];
  assign bias_on          = on_bits[SUP_BIAS];
  assign reset_on         = on_bits[SUP_RSTR];
  assign offset_on        = on_bits[SUP_OFFS];
  assign service_req_n    = 1'b0;
  assign service_req_n_oe = irq_oe;

  // ----------------------------------------------------------------
  // switching phase generator
  // ----------------------------------------------------------------
  logic [SW_CNT_W-1:0] sw_cnt, next_sw_cnt;
  logic                next_bias_sw, next_reset_sw;

  // two half-period phases; whole-cycle period, slightly above 1.5 MHz
  always_comb begin
    next_sw_cnt   = (sw_cnt == SW_CNT_W'(SW_PER - 1)) ? '0 : sw_cnt + 1'b1;
    next_bias_sw  = on_bits[SUP_BIAS] && (next_sw_cnt < SW_CNT_W'(SW_HALF));
    next_reset_sw = on_bits[SUP_RSTR] && (next_sw_cnt >= SW_CNT_W'(SW_HALF));
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sw_cnt             <= '0;
      bias_switch_drive  <= 1'b0;
      reset_switch_drive <= 1'b0;
    end else begin
      sw_cnt             <= next_sw_cnt;
      bias_switch_drive  <= next_bias_sw;
      reset_switch_drive <= next_reset_sw;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  AST_SW_EXCL: assert property (
    !(bias_switch_drive && reset_switch_drive))
    else $error("both switch phases on");
  AST_SW_PHASE: assert property (
    $rose(bias_switch_drive) && sw_cnt == '0 && reset_on |->
      ##33 ($rose(reset_switch_drive) || !reset_on))
    else $error("reset phase not half a period after bias");
  AST_SW_PERIOD: assert property (
    $rose(bias_switch_drive) && bias_on |-> ##66 (bias_switch_drive || !bias_on))
    else $error("bias phase period wrong");
  AST_DESEL_IDLE: assert property (
    sel_f |=> (state == ST_IDLE && !port_serial_out_oe && bit_cnt == 3'h0))
    else $error("slave not idle while deselected");
  AST_START: assert property (
    $fell(sel_f) |=> ##1 (state == ST_CMD && bit_cnt == 3'h0))
    else $error("select fall did not start access");
  AST_SAMPLE: assert property (
    sck_fall && !sel_f && state == ST_CMD |=> shreg[0] == $past(sdi_f))
    else $error("input bit not taken on falling edge");
  AST_OUT_EDGE: assert property (
    $rose(port_serial_out_oe) |-> $past(sck_rise))
    else $error("output changed away from rising edge");
  AST_WRITE: assert property (
    wr_en && cmd[ADDR_W-1:0] == ADR_BIAS |=> bias_level == $past(in_byte[LVL_W-1:0]))
    else $error("bias level write lost");
  AST_ABORT: assert property (
    $rose(sel_f) |=> $stable(bias_level) && $stable(reset_level) && $stable(offset_level))
    else $error("aborted access changed a control");
  AST_LATCH: assert property (
    |uv_lat && !wr_en |=> $past(uv_lat) == (uv_lat & $past(uv_lat)) && |uv_lat)
    else $error("latched fault dropped without clear");
  AST_IRQ: assert property (
    |{uv_live, cl_live} |=> service_req_n_oe ##1 (service_req_n_oe || !(|{uv_lat, cl_lat})))
    else $error("service request not raised for fault");
endmodule : spsc_top

// ---- sim/spsc_master.sv ----
// serial master model: drives clock, select and data for one access
// assumes the bench resolves the slave data line with a pull-up
`timescale 1ns/1ps
module spsc_master (
  output logic sck,   // serial clock, low between frames
  output logic sel_n, // access frame, low true
  output logic sdi,   // data towards the slave
  input  wire logic sdo // resolved data line from the slave
);
  initial begin
    sck   = 1'b0;
    sel_n = 1'b1;
    sdi   = 1'b0;
  end

  // ----------------------------------------------------------------
  // one access; fewer than 16 bits abandons it early
  // ----------------------------------------------------------------
  task automatic frame(input logic [15:0] word, input int nbits, input realtime half,
                       output logic [7:0] rd);
    rd = 8'h00;
    sel_n = 1'b0;
    #(half);
    for (int i = 0; i < nbits; i++) begin
      if (i == 8) #(2 * half);
      // data settles in the low phase
      sdi = word[15-i];
      // master alone clocks, any phase length
      #(half / 2) sck = 1'b1;
      #(half) sck = 1'b0;
      // sample late in the period, well after the slave's update
      #(half / 2);
      if (i >= 8) rd = {rd[6:0], sdo};
    end
    #(half);
    // select rises after the last bit or to abandon
    sel_n = 1'b1;
    sdi   = ~sdi; // released data is not left at the last value
  endtask : frame
endmodule : spsc_master

// ---- sim/tb_top.sv ----
// self-checking bench for the supply control serial port
// assumes pull-ups on both open-drain lines and a 125 ns serial clock
`timescale 1ns/1ps
module tb_top;
  import spsc_pkg::*;
  logic             ref_clk, reset, sck, sel_n, sdi, sdo, sdo_oe, srq, srq_oe, bdrv, rdrv;
  logic [NSUP-1:0]  uv, cl, on;
  logic [LVL_W-1:0] lvl [NSUP];
  logic [4:0]       mirror [NSUP];
  logic [7:0]       rd;
  logic [5:0]       f;
  int               num_errors, tests_run, cycles;
  wire              sdo_line = sdo_oe ? sdo : 1'b1; // pull-up when released
  wire              srq_line = srq_oe ? srq : 1'b1;

  spsc_top spsc_top_inst (.ref_clk(ref_clk), .reset(reset), .port_serial_clock(sck),
    .port_select_n(sel_n), .port_serial_in(sdi), .port_serial_out(sdo),
    .port_serial_out_oe(sdo_oe), .service_req_n(srq), .service_req_n_oe(srq_oe),
    .undervoltage_flag(uv), .current_limit_flag(cl), .bias_level(lvl[0]),
    .reset_level(lvl[1]), .offset_level(lvl[2]), .bias_on(on[0]), .reset_on(on[1]),
    .offset_on(on[2]), .bias_switch_drive(bdrv), .reset_switch_drive(rdrv));
  spsc_master spsc_master_inst (.sck(sck), .sel_n(sel_n), .sdi(sdi), .sdo(sdo_line));

  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;
  // about 70 accesses of 250 cycles plus one slow access of 7000
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      $display("wrong value at %0t: run did not finish", $time);
      test_done();
    end
  end

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk_byte({7'h00, got}, {7'h00, exp}, what);
  endtask : chk_bit

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  function automatic logic [7:0] ctl(input int s);
    return {3'h0, mirror[s]};
  endfunction : ctl

  // one access, then the idle gap the port needs between frames
  task automatic acc(input logic [7:0] cmd, input logic [7:0] dat, input int nbits,
                     input realtime half);
    // start just after an edge so no serial edge meets a sampling edge
    @(posedge ref_clk);
    #1;
    spsc_master_inst.frame({cmd, dat}, nbits, half, rd);
    repeat (12) @(posedge ref_clk);
    #1;
    chk_bit(sdo_oe, 1'b0, "data line released");
  endtask : acc

  task automatic flags(input logic [5:0] v);
    @(posedge ref_clk);
    #1 {cl, uv} = v;
    repeat (10) @(posedge ref_clk);
  endtask : flags

  // outputs and readback of every supply against the expected bytes
  task automatic chk_ctl();
    for (int s = 0; s < NSUP; s++) begin
      chk_byte({3'h0, on[s], lvl[s]}, ctl(s), "control outputs");
      acc({1'b1, 7'(s)}, 8'h00, 16, 62.5);
      chk_byte(rd, ctl(s), "control readback");
    end
  endtask : chk_ctl

  // count gate phases over four periods, sampled away from the edge
  task automatic chk_sw(input int exp_b, input int exp_r);
    int hb, hr, ov;
    hb = 0;
    hr = 0;
    ov = 0;
    for (int i = 0; i < 4 * SW_PER; i++) begin
      @(negedge ref_clk);
      hb += int'(bdrv === 1'b1);
      hr += int'(rdrv === 1'b1);
      ov += int'(bdrv === 1'b1 && rdrv === 1'b1);
    end
    chk_byte(8'(hb), 8'(exp_b), "bias phase cycles");
    chk_byte(8'(hr), 8'(exp_r), "reset phase cycles");
    chk_byte(8'(ov), 8'h00, "phase overlap");
  endtask : chk_sw

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    uv    = '0;
    cl    = '0;
    for (int s = 0; s < NSUP; s++) mirror[s] = 5'h00;
    void'($urandom(32'h31c30b28));
    repeat (3) @(posedge ref_clk);
    #1 reset = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    chk_bit(srq_line, 1'b1, "no request after reset");
    chk_sw(0, 0);
    chk_ctl();
    // random levels, corner values first
    for (int n = 0; n < 4; n++) begin
      for (int s = 0; s < NSUP; s++) begin
        mirror[s] = (n == 0) ? 5'h1f : 5'($urandom);
        acc({1'b0, 7'(s)}, ctl(s), 16, 62.5);
      end
      chk_ctl();
    end
    // both switchers on: half period each, opposite phase
    mirror[0] = 5'h15;
    mirror[1] = 5'h1a;
    acc({1'b0, ADR_BIAS}, ctl(0), 16, 62.5);
    acc({1'b0, ADR_RSTR}, ctl(1), 16, 62.5);
    chk_sw(2 * SW_PER, 2 * SW_PER);
    // abandoned accesses change nothing, next access starts clean
    acc({1'b0, ADR_BIAS}, 8'h0e, 12, 62.5);
    acc({1'b0, ADR_OFFS}, 8'h00, 5, 62.5);
    chk_ctl();
    // unmapped place reads zero and ignores writes
    acc({1'b0, 7'h7f}, 8'hff, 16, 62.5);
    acc({1'b1, 7'h05}, 8'h00, 16, 62.5);
    chk_byte(rd, 8'h00, "unmapped read");
    // very slow clock still works
    mirror[2] = 5'h13;
    acc({1'b0, ADR_OFFS}, ctl(2), 16, 2000.0);
    chk_ctl();
    // faults: live view follows the pins, latch holds, write ones clears
    for (int n = 0; n < 5; n++) begin
      f = (n == 0) ? 6'h24 : 6'($urandom);
      flags(f);
      acc({1'b1, ADR_LIVE}, 8'h00, 16, 62.5);
      chk_byte(rd, {2'b00, f}, "live faults");
      acc({1'b0, ADR_LIVE}, 8'h00, 16, 62.5);
      flags(6'h00);
      acc({1'b1, ADR_LIVE}, 8'h00, 16, 62.5);
      chk_byte(rd, 8'h00, "live faults gone");
      acc({1'b1, ADR_LATCH}, 8'h00, 16, 62.5);
      chk_byte(rd, {2'b00, f}, "latched faults");
      chk_bit(srq_line, f == 6'h00, "service request");
      acc({1'b0, ADR_LATCH}, 8'h3f, 16, 62.5);
      acc({1'b1, ADR_LATCH}, 8'h00, 16, 62.5);
      chk_byte(rd, 8'h00, "latch cleared");
      chk_bit(srq_line, 1'b1, "request withdrawn");
    end
    // bias off: its gate stays quiet, reset keeps running
    mirror[0] = 5'h05;
    acc({1'b0, ADR_BIAS}, ctl(0), 16, 62.5);
    chk_sw(0, 2 * SW_PER);
    test_done();
  end
endmodule : tb_top
